// ==== shared/hpi_pkg.sv ====
// constants and helpers shared by the host port modules
package hpi_pkg;
  localparam int ADDR_W    = 6;
  localparam int DATA_W    = 8;
  localparam int REG_DEPTH = 64;
  localparam int IRQ_SRC_N = 8;

  localparam logic [5:0] IRQ_ENABLE_ADDR = 6'h3d;
  localparam logic [5:0] IRQ_CONFIG_ADDR = 6'h3e;
  localparam logic [5:0] IRQ_STATUS_ADDR = 6'h3f;
  localparam int         IRQ_DRIVE_BIT   = 0;
  localparam logic [7:0] REG_RESET       = 8'h00;

  // synchronised pin bundle {cs, as, rd, wr, sel, style, addr, data}
  localparam logic [19:0] PIN_IDLE = 20'hf0000;

  localparam int CLOCK_HZ     = 40_000_000;
  localparam int WAIT_TIME_NS = 50;
  localparam int WAIT_CYCLES  =
    (WAIT_TIME_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;

  // serial frame layout
  localparam int CMD_BITS     = 8;
  localparam int TURN_BITS    = 16;
  localparam int CMD_READ_BIT = 7;
  localparam logic [7:0] NOT_READY_BYTE = 8'hff;

  function automatic logic [7:0] reverse_byte(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7 - i];
    end
    return r;
  endfunction
endpackage

// ==== shared/hpi_ser_if.sv ====
// request and answer words between the serial link and the core
`timescale 1ns/1ps
interface hpi_ser_if;
  logic       req_toggle;
  logic       req_read;
  logic [5:0] req_addr;
  logic [7:0] req_wdata;
  logic       ack_toggle;
  logic [7:0] ack_rdata;

  modport link (
    output req_toggle, req_read, req_addr, req_wdata,
    input  ack_toggle, ack_rdata
  );
  modport core (
    input  req_toggle, req_read, req_addr, req_wdata,
    output ack_toggle, ack_rdata
  );
endinterface

// ==== rtl/hpi_irq.sv ====
// sticky interrupt status and interrupt pin driver
`timescale 1ns/1ps
module hpi_irq #(
  parameter int SRC_N = hpi_pkg::IRQ_SRC_N
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [SRC_N-1:0] src_event,
  input  wire logic [SRC_N-1:0] enable,
  input  wire logic             drive_high,
  input  wire logic             clear_strobe,
  input  wire logic [SRC_N-1:0] clear_mask,
  output logic      [SRC_N-1:0] status,
  output logic                  irq_out_n,
  output logic                  irq_out_oe
);
  logic [SRC_N-1:0] status_reg;
  logic             irq_n_reg;
  logic             irq_oe_reg;
  logic             active;

  assign active     = |(status_reg & enable);
  assign status     = status_reg;
  assign irq_out_n  = irq_n_reg;
  assign irq_out_oe = irq_oe_reg;

  // set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~(clear_strobe ? clear_mask : '0))
                  | (src_event & enable);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq_n_reg  <= 1'b1;
      irq_oe_reg <= 1'b0;
    end else begin
      irq_n_reg  <= !active;
      irq_oe_reg <= active || drive_high;
    end
  end

  AST_IRQ_FLOAT_IN_RESET: assert property (
    @(posedge clock) !reset_n |=> !irq_out_oe)
    else $error("interrupt pin driven during reset");
  AST_IRQ_ASSERTS: assert property (
    @(posedge clock) disable iff (!reset_n)
    active |=> (!irq_out_n && irq_out_oe))
    else $error("enabled source did not pull interrupt low");
  AST_IRQ_OPEN_DRAIN_IDLE: assert property (
    @(posedge clock) disable iff (!reset_n)
    (!active && !drive_high) |=> !irq_out_oe)
    else $error("interrupt pin driven while idle in open drain");
endmodule

// ==== rtl/hpi_serial.sv ====
// serial host port engine, clocked by the host shift clock
`timescale 1ns/1ps
module hpi_serial #(
  parameter int TURN_BITS = hpi_pkg::TURN_BITS
) (
  input  wire logic  shift_clk,
  input  wire logic  reset_n,
  input  wire logic  chip_select_n,
  input  wire logic  serial_in,
  input  wire logic  out_edge_select,
  input  wire logic  bit_order_select,
  hpi_ser_if.link    lnk,
  output logic       serial_out,
  output logic       serial_out_oe
);
  localparam logic [5:0] CMD_LAST  = 6'(hpi_pkg::CMD_BITS - 1);
  localparam logic [5:0] WR_LAST   = 6'(2 * hpi_pkg::CMD_BITS - 1);
  localparam logic [5:0] DATA_LOAD = 6'(hpi_pkg::CMD_BITS + TURN_BITS - 1);
  localparam logic [5:0] CNT_MAX   = 6'h3f;

  logic [5:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] out_sr_reg;
  logic       read_reg;
  logic       oe_pos_reg;
  logic       oe_neg_reg;
  logic       out_neg_reg;
  logic       edge_meta_reg;
  logic       edge_sync_reg;
  logic       order_meta_reg;
  logic       order_sync_reg;
  logic       ack_meta_reg;
  logic       ack_sync_reg;
  logic [7:0] shift_next;
  logic [7:0] frame_byte;

  function automatic logic [7:0] ordered(input logic [7:0] b,
                                         input logic       lsb_first);
    return lsb_first ? hpi_pkg::reverse_byte(b) : b;
  endfunction

  assign shift_next = {shift_reg[6:0], serial_in};
  assign frame_byte = ordered(shift_next, order_sync_reg);

  // ---------------------------------------------------------------
  // frame logic
  // ---------------------------------------------------------------
  // chip select high clears the frame: the shift clock may stop there
  always_ff @(posedge shift_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      bit_cnt_reg    <= '0;
      shift_reg      <= '0;
      out_sr_reg     <= '0;
      read_reg       <= 1'b0;
      oe_pos_reg     <= 1'b0;
      edge_meta_reg  <= 1'b0;
      edge_sync_reg  <= 1'b0;
      order_meta_reg <= 1'b0;
      order_sync_reg <= 1'b0;
      ack_meta_reg   <= 1'b0;
      ack_sync_reg   <= 1'b0;
    end else begin
      edge_meta_reg  <= out_edge_select;
      edge_sync_reg  <= edge_meta_reg;
      order_meta_reg <= bit_order_select;
      order_sync_reg <= order_meta_reg;
      ack_meta_reg   <= lnk.ack_toggle;
      ack_sync_reg   <= ack_meta_reg;
      shift_reg      <= shift_next;
      if (bit_cnt_reg != CNT_MAX) begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
      if (bit_cnt_reg == CMD_LAST) begin
        read_reg <= frame_byte[hpi_pkg::CMD_READ_BIT];
      end
      // output stays off through command and turnaround bits
      if (read_reg && bit_cnt_reg == DATA_LOAD) begin
        out_sr_reg <= (ack_sync_reg == lnk.req_toggle)
                    ? ordered(lnk.ack_rdata, order_sync_reg)
                    : hpi_pkg::NOT_READY_BYTE;
        oe_pos_reg <= 1'b1;
      end else begin
        out_sr_reg <= {out_sr_reg[6:0], 1'b0};
      end
    end
  end

  // request words survive the frame; core sees them via the toggle
  always_ff @(posedge shift_clk or negedge reset_n) begin
    if (!reset_n) begin
      lnk.req_toggle <= 1'b0;
      lnk.req_read   <= 1'b0;
      lnk.req_addr   <= '0;
      lnk.req_wdata  <= '0;
    end else if (!chip_select_n) begin
      if (bit_cnt_reg == CMD_LAST) begin
        lnk.req_read <= frame_byte[hpi_pkg::CMD_READ_BIT];
        lnk.req_addr <= frame_byte[5:0];
        if (frame_byte[hpi_pkg::CMD_READ_BIT]) begin
          lnk.req_toggle <= !lnk.req_toggle;
        end
      end else if (!read_reg && bit_cnt_reg == WR_LAST) begin
        lnk.req_wdata  <= frame_byte;
        lnk.req_toggle <= !lnk.req_toggle;
      end
    end
  end

  always_ff @(negedge shift_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      out_neg_reg <= 1'b0;
      oe_neg_reg  <= 1'b0;
    end else begin
      out_neg_reg <= out_sr_reg[7];
      oe_neg_reg  <= oe_pos_reg;
    end
  end

  // high select launches on the rising edge, low on the falling edge
  assign serial_out    = edge_sync_reg ? out_sr_reg[7] : out_neg_reg;
  assign serial_out_oe = edge_sync_reg ? oe_pos_reg : oe_neg_reg;

  AST_SER_WRITE_QUIET: assert property (
    @(posedge shift_clk) disable iff (chip_select_n)
    (!read_reg && bit_cnt_reg > CMD_LAST) |-> (!oe_pos_reg && !oe_neg_reg))
    else $error("serial output enabled during a write");
  AST_SER_CMD_QUIET: assert property (
    @(posedge shift_clk) disable iff (chip_select_n)
    (bit_cnt_reg <= DATA_LOAD) |-> !oe_pos_reg)
    else $error("serial output enabled in command phase");
  AST_SER_SAMPLE_RISE: assert property (
    @(posedge shift_clk) disable iff (chip_select_n)
    1'b1 |=> (shift_reg[0] == $past(serial_in)))
    else $error("serial input not sampled on rising edge");
endmodule

// ==== rtl/hpi_top.sv ====
// host port: serial and parallel register access with interrupt pin
`timescale 1ns/1ps
module hpi_top #(
  parameter int SRC_N     = hpi_pkg::IRQ_SRC_N,
  parameter int TURN_BITS = hpi_pkg::TURN_BITS
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             shift_clk,
  input  wire logic             host_port_select,
  input  wire logic             bus_style_select,
  input  wire logic             chip_select_n,
  input  wire logic             addr_strobe_n,
  input  wire logic             read_strobe_n,
  input  wire logic             write_strobe_n,
  input  wire logic [5:0]       addr_in,
  input  wire logic [7:0]       data_in,
  input  wire logic             serial_in,
  input  wire logic             out_edge_select,
  input  wire logic             bit_order_select,
  input  wire logic [SRC_N-1:0] irq_source,
  output logic      [7:0]       data_out,
  output logic                  data_oe,
  output logic                  serial_out,
  output logic                  serial_out_oe,
  output logic                  wait_indicator_n,
  output logic                  cycle_done_n,
  output logic                  irq_out_n,
  output logic                  irq_out_oe
);
  typedef enum logic [1:0] {
    PAR_IDLE,
    PAR_WAIT,
    PAR_DONE
  } hpi_par_state_type;

  localparam logic [1:0] WAIT_LAST = 2'(hpi_pkg::WAIT_CYCLES - 1);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [19:0] pin_raw;
  logic [19:0] pin_meta_reg;
  logic [19:0] pin_sync_reg;
  logic [19:0] pin_prev_reg;

  assign pin_raw = {chip_select_n, addr_strobe_n, read_strobe_n,
                    write_strobe_n, host_port_select, bus_style_select,
                    addr_in, data_in};

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pin_meta_reg <= hpi_pkg::PIN_IDLE;
      pin_sync_reg <= hpi_pkg::PIN_IDLE;
      pin_prev_reg <= hpi_pkg::PIN_IDLE;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  logic       cs_n_s;
  logic       as_n_s;
  logic       rd_s;
  logic       wr_s;
  logic       par_mode;
  logic       style_one;
  logic [5:0] addr_s;
  logic [7:0] data_s;

  assign cs_n_s    = pin_sync_reg[19];
  assign as_n_s    = pin_sync_reg[18];
  assign rd_s      = pin_sync_reg[17];
  assign wr_s      = pin_sync_reg[16];
  assign par_mode  = pin_sync_reg[15];
  assign style_one = pin_sync_reg[14];
  assign addr_s    = pin_sync_reg[13:8];
  assign data_s    = pin_sync_reg[7:0];

  // style one: either strobe low; style two: data strobe low
  function automatic logic strobe_on(input logic [19:0] p);
    return !p[19] && (p[14] ? (!p[17] || !p[16]) : !p[16]);
  endfunction

  logic strobe_act;
  logic start;
  logic finish;
  logic as_fall;

  assign strobe_act = strobe_on(pin_sync_reg);
  assign start      = par_mode && strobe_act && !strobe_on(pin_prev_reg);
  assign finish     = !strobe_act && strobe_on(pin_prev_reg);
  assign as_fall    = pin_prev_reg[18] && !as_n_s;

  // ---------------------------------------------------------------
  // multiplexed address latch
  // ---------------------------------------------------------------
  // a host wired nonmultiplexed ties the strobe high, so no fall ever
  // arrives and the separate address pins are used instead
  logic       muxed_reg;
  logic [5:0] mux_addr_reg;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      muxed_reg    <= 1'b0;
      mux_addr_reg <= '0;
    end else if (par_mode && as_fall) begin
      muxed_reg    <= 1'b1;
      mux_addr_reg <= data_s[5:0];
    end
  end

  // ---------------------------------------------------------------
  // register file and read path
  // ---------------------------------------------------------------
  logic [7:0]       reg_array [hpi_pkg::REG_DEPTH];
  logic [SRC_N-1:0] irq_status;
  logic             wr_en;
  logic [5:0]       wr_addr;
  logic [7:0]       wr_data;

  function automatic logic [7:0] read_byte(input logic [5:0] a);
    logic [7:0] v;
    v = reg_array[a];
    if (a == hpi_pkg::IRQ_STATUS_ADDR) begin
      v = 8'(irq_status);
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // parallel cycle engine
  // ---------------------------------------------------------------
  hpi_par_state_type state_reg;
  logic [1:0]        wait_cnt_reg;
  logic [5:0]        cyc_addr_reg;
  logic              cyc_read_reg;
  logic [7:0]        data_out_reg;
  logic              data_oe_reg;
  logic              wait_n_reg;
  logic              done_n_reg;

  always_ff @(posedge clock) begin
    if (!reset_n || !par_mode) begin
      state_reg    <= PAR_IDLE;
      wait_cnt_reg <= '0;
      cyc_addr_reg <= '0;
      cyc_read_reg <= 1'b0;
      data_out_reg <= '0;
      data_oe_reg  <= 1'b0;
      wait_n_reg   <= 1'b0;
      done_n_reg   <= 1'b1;
    end else begin
      case (state_reg)
        PAR_IDLE: begin
          if (start) begin
            // nonmuxed address is taken at the strobe fall
            cyc_addr_reg <= muxed_reg ? mux_addr_reg : addr_s;
            cyc_read_reg <= style_one ? !rd_s : rd_s;
            wait_cnt_reg <= '0;
            wait_n_reg   <= style_one;
            state_reg    <= PAR_WAIT;
          end
        end
        PAR_WAIT: begin
          if (finish) begin
            wait_n_reg <= 1'b0;
            state_reg  <= PAR_IDLE;
          end else if (wait_cnt_reg == WAIT_LAST) begin
            if (cyc_read_reg) begin
              data_out_reg <= read_byte(cyc_addr_reg);
              data_oe_reg  <= 1'b1;
            end
            wait_n_reg <= 1'b0;
            done_n_reg <= style_one;
            state_reg  <= PAR_DONE;
          end else begin
            wait_cnt_reg <= wait_cnt_reg + 2'h1;
          end
        end
        PAR_DONE: begin
          // read data stays on the bus until the strobe rises
          if (finish) begin
            data_oe_reg <= 1'b0;
            done_n_reg  <= 1'b1;
            state_reg   <= PAR_IDLE;
          end
        end
        default: begin
          state_reg <= PAR_IDLE;
        end
      endcase
    end
  end

  assign data_out         = data_out_reg;
  assign data_oe          = data_oe_reg;
  assign wait_indicator_n = wait_n_reg;
  assign cycle_done_n     = done_n_reg;

  // ---------------------------------------------------------------
  // serial request service
  // ---------------------------------------------------------------
  hpi_ser_if ser ();

  logic req_meta_reg;
  logic req_sync_reg;
  logic req_seen_reg;
  logic ser_new;
  logic ack_toggle_reg;
  logic [7:0] ack_rdata_reg;

  assign ser_new        = !par_mode && (req_sync_reg != req_seen_reg);
  assign ser.ack_toggle = ack_toggle_reg;
  assign ser.ack_rdata  = ack_rdata_reg;

  // request words are stable once the toggle has crossed
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      req_meta_reg   <= 1'b0;
      req_sync_reg   <= 1'b0;
      req_seen_reg   <= 1'b0;
      ack_toggle_reg <= 1'b0;
      ack_rdata_reg  <= '0;
    end else begin
      req_meta_reg <= ser.req_toggle;
      req_sync_reg <= req_meta_reg;
      if (ser_new) begin
        req_seen_reg   <= req_sync_reg;
        ack_toggle_reg <= req_sync_reg;
        if (ser.req_read) begin
          ack_rdata_reg <= read_byte(ser.req_addr);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  logic par_wr;

  // data pins are sampled as the write strobe goes back high
  assign par_wr  = par_mode && finish && state_reg != PAR_IDLE
                && !cyc_read_reg;
  assign wr_en   = par_wr || (ser_new && !ser.req_read);
  assign wr_addr = par_wr ? cyc_addr_reg : ser.req_addr;
  assign wr_data = par_wr ? data_s : ser.req_wdata;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      for (int i = 0; i < hpi_pkg::REG_DEPTH; i++) begin
        reg_array[i] <= hpi_pkg::REG_RESET;
      end
    end else if (wr_en && wr_addr != hpi_pkg::IRQ_STATUS_ADDR) begin
      reg_array[wr_addr] <= wr_data;
    end
  end

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  hpi_serial #(
    .TURN_BITS (TURN_BITS)
  ) u_serial (
    .shift_clk        (shift_clk),
    .reset_n          (reset_n),
    .chip_select_n    (chip_select_n),
    .serial_in        (serial_in),
    .out_edge_select  (out_edge_select),
    .bit_order_select (bit_order_select),
    .lnk              (ser.link),
    .serial_out       (serial_out),
    .serial_out_oe    (serial_out_oe)
  );

  hpi_irq #(
    .SRC_N (SRC_N)
  ) u_irq (
    .clock        (clock),
    .reset_n      (reset_n),
    .src_event    (irq_source),
    .enable       (reg_array[hpi_pkg::IRQ_ENABLE_ADDR][SRC_N-1:0]),
    .drive_high   (reg_array[hpi_pkg::IRQ_CONFIG_ADDR]
                            [hpi_pkg::IRQ_DRIVE_BIT]),
    .clear_strobe (wr_en && wr_addr == hpi_pkg::IRQ_STATUS_ADDR),
    .clear_mask   (wr_data[SRC_N-1:0]),
    .status       (irq_status),
    .irq_out_n    (irq_out_n),
    .irq_out_oe   (irq_out_oe)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_WAIT_WINDOW: assert property (
    @(posedge clock) disable iff (!reset_n)
    (start && style_one) |=> wait_indicator_n ##2 !wait_indicator_n)
    else $error("wait indicator window wrong");
  AST_ACK_DONE: assert property (
    @(posedge clock) disable iff (!reset_n)
    (start && !style_one) ##1 strobe_act [*2] |=> !cycle_done_n)
    else $error("acknowledge not given after cycle");
  AST_ADDR_LATCH: assert property (
    @(posedge clock) disable iff (!reset_n)
    (par_mode && as_fall) |=> (mux_addr_reg == $past(data_s[5:0])))
    else $error("multiplexed address not latched");
  AST_SERIAL_MODE_IDLE: assert property (
    @(posedge clock) disable iff (!reset_n)
    !par_mode |=> (state_reg == PAR_IDLE && !data_oe))
    else $error("parallel engine active in serial mode");
  AST_ENABLES_CLEARED: assert property (
    @(posedge clock)
    !reset_n |=> (reg_array[hpi_pkg::IRQ_ENABLE_ADDR] == 8'h00))
    else $error("interrupt enables survive reset");
endmodule

// ==== verif/hpi_host.sv ====
// host side model: parallel strobe cycles and serial frames
`timescale 1ns/1ps
module hpi_host (
  input  wire logic       clock,
  input  wire logic       wait_indicator_n,
  input  wire logic       cycle_done_n,
  input  wire logic [7:0] data_out,
  input  wire logic       serial_out,
  input  wire logic       serial_out_oe,
  input  wire logic       data_oe,
  output logic            addr_strobe_n,
  output logic            chip_select_n,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic      [5:0] addr_in,
  output logic      [7:0] data_in,
  output logic            shift_clk,
  output logic            serial_in
);
  initial begin
    {chip_select_n, read_strobe_n, write_strobe_n} = 3'h7;
    // strobe stays tied high unless a multiplexed phase is modelled
    addr_strobe_n = 1'b1;
    addr_in = 6'h00;
    data_in = 8'h00;
    shift_clk = 1'b0;
    serial_in = 1'b0;
  end
  // w is -1 when the cycle never completes
  task automatic par(input logic one, input logic rd, input logic [5:0] a,
                     input logic [7:0] d, output logic [7:0] q, output int w);
    int n;
    w = 0;
    @(posedge clock);
    chip_select_n <= 1'b0;
    addr_in <= a;
    data_in <= d;
    read_strobe_n <= one ? ~rd : rd;
    write_strobe_n <= one ? rd : 1'b0;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      #1;
      if (wait_indicator_n === 1'b1) w++;
      if (one ? w > 0 && wait_indicator_n === 1'b0 : cycle_done_n === 1'b0)
        break;
    end
    // an undriven bus reads back as the inverse
    q = data_oe ? data_out : ~data_out;
    if (n == 20) w = -1;
    @(posedge clock);
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    // data held past the strobe rise, then scrambled as a released bus
    repeat (3) @(posedge clock);
    data_in <= ~d;
    chip_select_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask
  // multiplexed address phase: address rides on the data pins
  task automatic mux(input logic [5:0] a);
    @(posedge clock);
    chip_select_n <= 1'b0;
    data_in <= {2'h0, a};
    addr_strobe_n <= 1'b0;
    repeat (3) @(posedge clock);
    addr_strobe_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
  // shift clock stands still outside the frame
  task automatic ser(input logic rd, input logic [5:0] a, input logic [7:0] d,
                     input logic lsb, output logic [7:0] q, output int bad);
    logic [7:0] b;
    q = 8'h00;
    bad = 0;
    chip_select_n = 1'b0;
    #10;
    for (int i = 0; i < (rd ? 31 : 16); i++) begin
      b = i < 8 ? {rd, 1'b0, a} : d;
      serial_in = b[lsb ? i % 8 : 7 - i % 8];
      #5 shift_clk = 1'b1;
      #6 shift_clk = 1'b0;
      // look once a falling-edge launch has settled
      #1;
      if (serial_out_oe !== (rd && i >= 23)) bad++;
      if (rd && i >= 23) q[lsb ? i - 23 : 30 - i] = serial_out;
    end
    #10 chip_select_n = 1'b1;
    serial_in = ~serial_in;
    repeat (6) @(posedge clock);
  endtask
endmodule

// ==== verif/hpi_top_bench.sv ====
// self-checking bench for the host port
`timescale 1ns/1ps
module hpi_top_bench;
  logic       clock, reset_n, host_port_select, bus_style_select;
  logic       cs_n, rd_n, wr_n, sclk, sin, ser_out, ser_oe, as_n, doe;
  logic       wait_n, done_n, irq_n, irq_oe, edge_sel, bit_order_select;
  logic [5:0] addr;
  logic [7:0] din, dout, src, q;
  int         errors = 0;
  int         tests_run = 0;

  hpi_top dut_u (.clock(clock), .reset_n(reset_n), .shift_clk(sclk),
    .host_port_select(host_port_select), .bus_style_select(bus_style_select),
    .chip_select_n(cs_n), .addr_strobe_n(as_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .addr_in(addr), .data_in(din), .serial_in(sin),
    .out_edge_select(edge_sel), .bit_order_select(bit_order_select),
    .irq_source(src), .data_out(dout), .data_oe(doe), .serial_out(ser_out),
    .serial_out_oe(ser_oe), .wait_indicator_n(wait_n),
    .cycle_done_n(done_n), .irq_out_n(irq_n), .irq_out_oe(irq_oe));
  hpi_host host_u (.clock(clock), .wait_indicator_n(wait_n),
    .cycle_done_n(done_n), .data_out(dout), .serial_out(ser_out),
    .data_oe(doe), .addr_strobe_n(as_n),
    .serial_out_oe(ser_oe), .chip_select_n(cs_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .addr_in(addr), .data_in(din), .shift_clk(sclk),
    .serial_in(sin));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // ------------------------------------------------------------
  // compare and report
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic pc(input logic rd, input logic [5:0] a, input logic [7:0] d);
    int w;
    host_u.par(bus_style_select, rd, a, d, q, w);
    if (w < 0) begin
      errors++;
      results;
    end
    if (bus_style_select) chk(8'(w), 8'(hpi_pkg::WAIT_CYCLES));
  endtask
  task automatic pulse(input logic [7:0] s, input logic [7:0] exp);
    src <= s;
    @(posedge clock);
    src <= 8'h00;
    repeat (3) @(posedge clock);
    chk({6'h00, irq_n, irq_oe}, exp);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_irq;
    pulse(8'h02, 8'h02);
    pc(0, 6'h3d, 8'h01);
    pc(1, 6'h3d, 8'h00);
    chk(q, 8'h01);
    pulse(8'h01, 8'h01);
    pc(0, 6'h3f, 8'hff);
    chk({6'h00, irq_n, irq_oe}, 8'h02);
    pc(0, 6'h3e, 8'h01);
    chk({6'h00, irq_n, irq_oe}, 8'h03);
  endtask
  task automatic t_style_two;
    bus_style_select <= 1'b0;
    repeat (4) @(posedge clock);
    pc(0, 6'h05, 8'ha5);
    pc(1, 6'h05, 8'h00);
    chk(q, 8'ha5);
    chk({7'h00, done_n}, 8'h01);
  endtask
  task automatic t_serial;
    int bad;
    host_port_select <= 1'b0;
    repeat (4) @(posedge clock);
    host_u.ser(0, 6'h06, 8'h3c, 0, q, bad);
    chk(8'(bad), 8'h00);
    host_u.ser(1, 6'h06, 8'h00, 0, q, bad);
    chk(q, 8'h3c);
    chk(8'(bad), 8'h00);
    bit_order_select <= 1'b1;
    @(posedge clock);
    host_u.ser(0, 6'h07, 8'h12, 1, q, bad);
    host_u.ser(1, 6'h05, 8'h00, 1, q, bad);
    chk(q, 8'ha5);
    edge_sel <= 1'b0;
    host_u.ser(1, 6'h06, 8'h00, 1, q, bad);
    chk(q, 8'h3c);
    chk(8'(bad), 8'h00);
    host_port_select <= 1'b1;
    bus_style_select <= 1'b1;
    repeat (4) @(posedge clock);
    pc(1, 6'h07, 8'h00);
    chk(q, 8'h12);
  endtask
  // mid-run reset, then multiplexed address phases in both styles
  task automatic t_mux;
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk({6'h00, irq_n, irq_oe}, 8'h02);
    @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    #1 chk({6'h00, irq_n, irq_oe}, 8'h02);
    pc(1, 6'h3d, 8'h00);
    chk(q, 8'h00);
    host_u.mux(6'h09);
    pc(0, 6'h2a, 8'h5a);
    host_u.mux(6'h09);
    pc(1, 6'h09, 8'h00);
    chk(q, 8'h5a);
    bus_style_select <= 1'b0;
    repeat (4) @(posedge clock);
    host_u.mux(6'h0b);
    pc(0, 6'h2b, 8'h66);
    host_u.mux(6'h0b);
    pc(1, 6'h0b, 8'h00);
    chk(q, 8'h66);
  endtask

  initial begin
    reset_n <= 1'b0;
    host_port_select = 1'b1;
    bus_style_select = 1'b1;
    edge_sel = 1'b1;
    bit_order_select = 1'b0;
    src = 8'h00;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    #1 chk({5'h00, irq_oe, irq_n, done_n}, 8'h03);
    repeat (4) @(posedge clock);
    t_irq;
    t_style_two;
    t_serial;
    t_mux;
    results;
  end
endmodule
